// ---- gpio_port_data_led_drive.sv ----
// Port data registers, second alternate select subregister and Port C LED sink control
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps
module gpio_port_data_led_drive
  import gpio_port_pkg::*;
#(
  parameter logic SMALL_PACKAGE = 1'b0,
  parameter logic [7:0] PORT_A_BONDED = 8'hFF,
  parameter logic [7:0] PORT_B_BONDED = 8'hFF,
  parameter logic [7:0] PORT_C_BONDED = 8'hFF
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic [23:0] pin_in,
  output logic [23:0] pin_out,
  output logic [23:0] pin_oe,
  input wire logic [23:0] alt_out,
  input wire logic [23:0] alt_oe,
  output logic [23:0] alt_set2_active,
  output logic [7:0] led_sink_on,
  output logic [15:0] led_level_code
);

  localparam logic [23:0] BONDED = {PORT_C_BONDED, PORT_B_BONDED, PORT_A_BONDED};

  // ==========================================
  // State
  logic [7:0] sub_addr [PORT_COUNT];
  logic [7:0] output_value [PORT_COUNT];
  logic [7:0] direction [PORT_COUNT];
  logic [7:0] alt_enable [PORT_COUNT];
  logic [7:0] open_drain [PORT_COUNT];
  logic [7:0] alt_function_select_second [PORT_COUNT];
  logic [7:0] led_sink_enable;
  logic [7:0] led_level_upper_bits;
  logic [7:0] led_level_lower_bits;
  logic [7:0] next_sub_addr [PORT_COUNT];
  logic [7:0] next_output_value [PORT_COUNT];
  logic [7:0] next_direction [PORT_COUNT];
  logic [7:0] next_alt_enable [PORT_COUNT];
  logic [7:0] next_open_drain [PORT_COUNT];
  logic [7:0] next_alt_second [PORT_COUNT];
  logic [7:0] next_led_sink_enable;
  logic [7:0] next_led_level_upper_bits;
  logic [7:0] next_led_level_lower_bits;
  logic [7:0] next_reg_rdata;
  logic [23:0] pin_stable;
  logic [7:0] pin_sample [PORT_COUNT];

  function automatic logic [7:0] port_base(input int p);
    case (p)
      0: port_base = 8'hD0;
      1: port_base = 8'hD4;
      default: port_base = 8'hD8;
    endcase
  endfunction

  function automatic logic [11:0] sub_ctrl_addr(input int p);
    case (p)
      0: sub_ctrl_addr = PORT_A_SUBCTRL_ADDR;
      1: sub_ctrl_addr = PORT_B_SUBCTRL_ADDR;
      default: sub_ctrl_addr = PORT_C_SUBCTRL_ADDR;
    endcase
  endfunction

  function automatic logic [11:0] sub_addr_addr(input int p);
    case (p)
      0: sub_addr_addr = PORT_A_SUBADDR_ADDR;
      1: sub_addr_addr = PORT_B_SUBADDR_ADDR;
      default: sub_addr_addr = PORT_C_SUBADDR_ADDR;
    endcase
  endfunction

  function automatic logic [11:0] out_addr(input int p);
    case (p)
      0: out_addr = PORT_A_OUTPUT_ADDR;
      1: out_addr = PORT_B_OUTPUT_ADDR;
      default: out_addr = PORT_C_OUTPUT_ADDR;
    endcase
  endfunction

  function automatic logic [11:0] sample_addr(input int p);
    case (p)
      0: sample_addr = PORT_A_SAMPLE_ADDR;
      1: sample_addr = PORT_B_SAMPLE_ADDR;
      default: sample_addr = PORT_C_SAMPLE_ADDR;
    endcase
  endfunction

  // ==========================================
  // Pin paths
  pin_sync #(.WIDTH(24)) u_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .pin_level(pin_in),
    .pin_stable(pin_stable)
  );

  for (genvar p = 0; p < PORT_COUNT; p++) begin : g_port
    assign pin_sample[p] = pin_stable[p*8 +: 8] & BONDED[p*8 +: 8];
    pin_driver #(.WIDTH(8)) u_drv (
      .output_value(output_value[p]),
      .direction_in(direction[p]),
      .open_drain(open_drain[p]),
      .alt_enable(alt_enable[p]),
      .alt_select_second(alt_function_select_second[p]),
      .alt_out(alt_out[p*8 +: 8]),
      .alt_oe(alt_oe[p*8 +: 8]),
      .bonded(BONDED[p*8 +: 8]),
      .pin_out(pin_out[p*8 +: 8]),
      .pin_oe(pin_oe[p*8 +: 8]),
      .alt_set2_active(alt_set2_active[p*8 +: 8])
    );
  end

  // ==========================================
  // LED sink outputs
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      led_sink_on[i] = led_sink_enable[i];
      // per pin two bit level code
      led_level_code[i*2 +: 2] = {led_level_upper_bits[i], led_level_lower_bits[i]};
    end
  end

  // ==========================================
  // Register writes and read data
  always_comb begin
    next_led_sink_enable = led_sink_enable;
    next_led_level_upper_bits = led_level_upper_bits;
    next_led_level_lower_bits = led_level_lower_bits;
    next_reg_rdata = 8'h00;
    for (int p = 0; p < PORT_COUNT; p++) begin
      next_sub_addr[p] = sub_addr[p];
      next_output_value[p] = output_value[p];
      next_direction[p] = direction[p];
      next_alt_enable[p] = alt_enable[p];
      next_open_drain[p] = open_drain[p];
      next_alt_second[p] = alt_function_select_second[p];
    end
    if (reg_write) begin
      if (reg_addr == LED_SINK_ENABLE_ADDR) begin
        next_led_sink_enable = reg_wdata;
      end
      if (reg_addr == LED_LEVEL_UPPER_ADDR) begin
        next_led_level_upper_bits = reg_wdata;
      end
      if (reg_addr == LED_LEVEL_LOWER_ADDR) begin
        next_led_level_lower_bits = reg_wdata;
      end
      for (int p = 0; p < PORT_COUNT; p++) begin
        if (reg_addr == sub_addr_addr(p)) begin
          next_sub_addr[p] = reg_wdata;
        end
        if (reg_addr == out_addr(p)) begin
          next_output_value[p] = reg_wdata;
        end
        if (reg_addr == sub_ctrl_addr(p)) begin
          case (sub_addr[p])
            SUB_DIRECTION: next_direction[p] = reg_wdata;
            SUB_ALT_ENABLE: next_alt_enable[p] = reg_wdata;
            SUB_OPEN_DRAIN: next_open_drain[p] = reg_wdata;
            SUB_ALT_SELECT_SECOND: next_alt_second[p] = reg_wdata;
            default: next_alt_second[p] = alt_function_select_second[p];
          endcase
        end
      end
    end
    if (reg_read) begin
      if (reg_addr == LED_SINK_ENABLE_ADDR) next_reg_rdata = led_sink_enable;
      if (reg_addr == LED_LEVEL_UPPER_ADDR) next_reg_rdata = led_level_upper_bits;
      if (reg_addr == LED_LEVEL_LOWER_ADDR) next_reg_rdata = led_level_lower_bits;
      for (int p = 0; p < PORT_COUNT; p++) begin
        if (reg_addr == sub_addr_addr(p)) next_reg_rdata = sub_addr[p];
        if (reg_addr == out_addr(p)) next_reg_rdata = output_value[p];
        if (reg_addr == sample_addr(p)) next_reg_rdata = pin_sample[p];
        if (reg_addr == sub_ctrl_addr(p)) begin
          case (sub_addr[p])
            SUB_DIRECTION: next_reg_rdata = direction[p];
            SUB_ALT_ENABLE: next_reg_rdata = alt_enable[p];
            SUB_OPEN_DRAIN: next_reg_rdata = open_drain[p];
            SUB_ALT_SELECT_SECOND: next_reg_rdata = alt_function_select_second[p];
            default: next_reg_rdata = 8'h00;
          endcase
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      led_sink_enable <= LED_RESET;
      led_level_upper_bits <= LED_RESET;
      led_level_lower_bits <= LED_RESET;
      reg_rdata <= 8'h00;
      for (int p = 0; p < PORT_COUNT; p++) begin
        sub_addr[p] <= SUBREG_RESET;
        output_value[p] <= OUTPUT_VALUE_RESET;
        direction[p] <= DIRECTION_RESET;
        alt_enable[p] <= SUBREG_RESET;
        open_drain[p] <= SUBREG_RESET;
        alt_function_select_second[p] <= (SMALL_PACKAGE && p == 0) ?
            ALT_SECOND_RESET_SMALL_A : ALT_SECOND_RESET;
      end
    end else begin
      led_sink_enable <= next_led_sink_enable;
      led_level_upper_bits <= next_led_level_upper_bits;
      led_level_lower_bits <= next_led_level_lower_bits;
      reg_rdata <= next_reg_rdata;
      for (int p = 0; p < PORT_COUNT; p++) begin
        sub_addr[p] <= next_sub_addr[p];
        output_value[p] <= next_output_value[p];
        direction[p] <= next_direction[p];
        alt_enable[p] <= next_alt_enable[p];
        open_drain[p] <= next_open_drain[p];
        alt_function_select_second[p] <= next_alt_second[p];
      end
    end
  end

  // ==========================================
  // Assertions
  a_sample_read_data: assert property (@(posedge ref_clk) disable iff (reset)
    reg_read && reg_addr == PORT_C_SAMPLE_ADDR |=> reg_rdata == $past(pin_sample[2]))
    else $error("input data read mismatch");
  // Skips the two edges after reset, while the chain still holds its cleared value
  a_sample_two_flops: assert property (@(posedge ref_clk) disable iff (reset)
    !$past(reset) && !$past(reset, 2) |-> pin_stable == $past(pin_in, 2))
    else $error("pin sample not two cycles late");
  a_unbonded_reads_zero: assert property (@(posedge ref_clk) disable iff (reset)
    (pin_sample[2] & ~PORT_C_BONDED) == 8'h00)
    else $error("unbonded pin read nonzero");
  a_indirect_write_hits: assert property (@(posedge ref_clk) disable iff (reset)
    reg_write && reg_addr == PORT_B_SUBCTRL_ADDR && sub_addr[1] == SUB_ALT_SELECT_SECOND
    |=> alt_function_select_second[1] == $past(reg_wdata))
    else $error("second select write lost");
  a_indirect_other_code: assert property (@(posedge ref_clk) disable iff (reset)
    reg_write && sub_addr[0] != SUB_ALT_SELECT_SECOND |=> $stable(alt_function_select_second[0]))
    else $error("second select written at wrong code");
  a_open_drain_high: assert property (@(posedge ref_clk) disable iff (reset)
    open_drain[0][0] && output_value[0][0] && !alt_enable[0][0] |-> !pin_oe[0])
    else $error("open drain drove high");
  a_output_drives: assert property (@(posedge ref_clk) disable iff (reset)
    !direction[1][3] && !alt_enable[1][3] && !open_drain[1][3] && BONDED[11]
    |-> pin_oe[11] && pin_out[11] == output_value[1][3])
    else $error("output data not driven");
  a_alt_needs_enable: assert property (@(posedge ref_clk) disable iff (reset)
    !alt_enable[2][5] |-> !alt_set2_active[21])
    else $error("alternate routed without enable");
  a_led_follows_enable: assert property (@(posedge ref_clk) disable iff (reset)
    reg_write && reg_addr == LED_SINK_ENABLE_ADDR |=> led_sink_on == $past(reg_wdata))
    else $error("led sink not following enable");
  a_led_level_code: assert property (@(posedge ref_clk) disable iff (reset)
    led_level_code[15:14] == {led_level_upper_bits[7], led_level_lower_bits[7]})
    else $error("led level code wrong");
  a_second_select_reset: assert property (@(posedge ref_clk) disable iff (reset)
    $fell(reset) |-> alt_function_select_second[2] == ALT_SECOND_RESET
    && alt_function_select_second[0] == (SMALL_PACKAGE ? ALT_SECOND_RESET_SMALL_A
    : ALT_SECOND_RESET))
    else $error("second select reset value wrong");
  a_reset_values: assert property (@(posedge ref_clk) disable iff (reset)
    $fell(reset) |-> output_value[1] == OUTPUT_VALUE_RESET && led_sink_on == LED_RESET
    && led_level_code == {LED_RESET, LED_RESET})
    else $error("register reset value wrong");
  a_sample_read_only: assert property (@(posedge ref_clk) disable iff (reset)
    reg_write && reg_addr == PORT_A_SAMPLE_ADDR
    |=> $stable(output_value[0]) && $stable(sub_addr[0]))
    else $error("write reached read-only sample register");
  a_rdata_idle: assert property (@(posedge ref_clk) disable iff (reset)
    !reg_read |=> reg_rdata == 8'h00)
    else $error("read data stood past its cycle");
  a_level_pairs_apart: assert property (@(posedge ref_clk) disable iff (reset)
    reg_write && reg_addr == LED_LEVEL_UPPER_ADDR |=> $stable(led_level_lower_bits))
    else $error("upper level write disturbed lower bits");

  c_led_full_current: cover property (@(posedge ref_clk) led_level_code[1:0] == LED_20MA);
  c_alt_second_write: cover property (@(posedge ref_clk)
    reg_write && reg_addr == PORT_A_SUBCTRL_ADDR && sub_addr[0] == SUB_ALT_SELECT_SECOND);
  c_open_drain_low: cover property (@(posedge ref_clk) open_drain[2][0] && pin_oe[16]);
  c_led_sink_with_alt: cover property (@(posedge ref_clk) led_sink_on[1] && alt_enable[2][1]);

endmodule

// ---- gpio_port_pkg.sv ----
// Package: register offsets, subregister codes, reset values and LED level codes
package gpio_port_pkg;

  // ==========================================
  // Register offsets (byte addresses on the register port)
  localparam logic [11:0] LED_SINK_ENABLE_ADDR = 12'hF82;
  localparam logic [11:0] LED_LEVEL_UPPER_ADDR = 12'hF83;
  localparam logic [11:0] LED_LEVEL_LOWER_ADDR = 12'hF84;
  localparam logic [11:0] PORT_A_SAMPLE_ADDR = 12'hFD2;
  localparam logic [11:0] PORT_A_OUTPUT_ADDR = 12'hFD3;
  localparam logic [11:0] PORT_B_SAMPLE_ADDR = 12'hFD6;
  localparam logic [11:0] PORT_B_OUTPUT_ADDR = 12'hFD7;
  localparam logic [11:0] PORT_C_SAMPLE_ADDR = 12'hFDA;
  localparam logic [11:0] PORT_C_OUTPUT_ADDR = 12'hFDB;
  // Indirect access pair for the port subregister bank
  localparam logic [11:0] PORT_A_SUBADDR_ADDR = 12'hFD0;
  localparam logic [11:0] PORT_A_SUBCTRL_ADDR = 12'hFD1;
  localparam logic [11:0] PORT_B_SUBADDR_ADDR = 12'hFD4;
  localparam logic [11:0] PORT_B_SUBCTRL_ADDR = 12'hFD5;
  localparam logic [11:0] PORT_C_SUBADDR_ADDR = 12'hFD8;
  localparam logic [11:0] PORT_C_SUBCTRL_ADDR = 12'hFD9;

  // ==========================================
  // Subregister codes held in the port address register
  localparam logic [7:0] SUB_DIRECTION = 8'h01;
  localparam logic [7:0] SUB_ALT_ENABLE = 8'h02;
  localparam logic [7:0] SUB_OPEN_DRAIN = 8'h03;
  localparam logic [7:0] SUB_ALT_SELECT_SECOND = 8'h08;

  // ==========================================
  // Reset values
  localparam logic [7:0] OUTPUT_VALUE_RESET = 8'h00;
  localparam logic [7:0] LED_RESET = 8'h00;
  localparam logic [7:0] ALT_SECOND_RESET = 8'h00;
  localparam logic [7:0] ALT_SECOND_RESET_SMALL_A = 8'h04;
  localparam logic [7:0] DIRECTION_RESET = 8'hFF;
  localparam logic [7:0] SUBREG_RESET = 8'h00;

  // ==========================================
  // LED sink current codes {upper, lower}
  typedef enum logic [1:0] {
    LED_3MA = 2'b00,
    LED_7MA = 2'b01,
    LED_13MA = 2'b10,
    LED_20MA = 2'b11
  } led_level_e;

  localparam int PORT_COUNT = 3;
  localparam int PIN_COUNT = 8;

endpackage

// ---- pin_sync.sv ----
// Two-flop synchroniser for the pin levels of all three ports
`timescale 1ns/100ps
module pin_sync
  import gpio_port_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pin_level,
  output logic [WIDTH-1:0] pin_stable
);

  logic [WIDTH-1:0] stage_one;
  logic [WIDTH-1:0] next_stage_one;
  logic [WIDTH-1:0] next_pin_stable;

  // ==========================================
  // Synchroniser
  always_comb begin
    next_stage_one = pin_level;
    next_pin_stable = stage_one;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      stage_one <= '0;
      pin_stable <= '0;
    end else begin
      stage_one <= next_stage_one;
      pin_stable <= next_pin_stable;
    end
  end

endmodule

// ---- pin_driver.sv ----
// Per-port pin drive: output data, direction, open drain, alternate routing
`timescale 1ns/100ps
module pin_driver
  import gpio_port_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] output_value,
  input wire logic [WIDTH-1:0] direction_in,
  input wire logic [WIDTH-1:0] open_drain,
  input wire logic [WIDTH-1:0] alt_enable,
  input wire logic [WIDTH-1:0] alt_select_second,
  input wire logic [WIDTH-1:0] alt_out,
  input wire logic [WIDTH-1:0] alt_oe,
  input wire logic [WIDTH-1:0] bonded,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe,
  output logic [WIDTH-1:0] alt_set2_active
);

  // ==========================================
  // Drive selection
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      // select bit routes only with enable
      alt_set2_active[i] = alt_enable[i] & alt_select_second[i];
      if (alt_enable[i]) begin
        pin_out[i] = alt_out[i];
        pin_oe[i] = alt_oe[i] & bonded[i];
      end else begin
        // data drives only as plain output
        pin_out[i] = output_value[i];
        pin_oe[i] = ~direction_in[i] & bonded[i] & ~(open_drain[i] & output_value[i]);
      end
    end
  end

endmodule

// ---- pin_load_model.sv ----
// Far-side model: package pins with the block's drive and an external source
`timescale 1ns/100ps
module pin_load_model (
  input wire logic [23:0] pin_out,
  input wire logic [23:0] pin_oe,
  input wire logic [23:0] ext_level,
  output logic [23:0] pin_level
);
  // ==========================================
  // Pin resolution
  // Undriven pins show the outside source, so a stale block value never reads back
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
    end
  end
endmodule

// ---- test_gpio_port_data_led_drive.sv ----
// Self-checking bench for port data, second select and Port C LED sink control
`timescale 1ns/100ps
module test_gpio_port_data_led_drive
  import gpio_port_pkg::*;
;
  localparam logic [7:0] C_BONDED = 8'h0F;
  logic ref_clk, reset, reg_write, reg_read;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, led_sink_on;
  logic [23:0] pin_in, pin_out, pin_oe, alt_out, alt_oe, alt_set2_active, ext_level;
  logic [15:0] led_level_code, exp_code;
  logic [7:0] hi, lo;
  logic [7:0] small_rdata;
  int bad_count, num_checks, cycles;

  // ==========================================
  // Design and far side
  // Upper half of Port C left unbonded to exercise zero reads
  gpio_port_data_led_drive #(.PORT_C_BONDED(C_BONDED)) dut (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .alt_out(alt_out), .alt_oe(alt_oe),
    .alt_set2_active(alt_set2_active), .led_sink_on(led_sink_on),
    .led_level_code(led_level_code));
  pin_load_model loads (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
    .pin_level(pin_in));
  // Smallest package variant on the same register port, read back beside dut
  gpio_port_data_led_drive #(.SMALL_PACKAGE(1'b1)) dut_small (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(small_rdata), .pin_in(pin_in),
    .pin_out(), .pin_oe(), .alt_out(alt_out), .alt_oe(alt_oe), .alt_set2_active(),
    .led_sink_on(), .led_level_code());

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ==========================================
  // Tasks
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string what);
    @(posedge ref_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1;
    chk(what, {16'h0000, exp}, {16'h0000, reg_rdata});
  endtask

  task automatic sub_wr(input int p, input logic [7:0] code, input logic [7:0] d);
    wr(PORT_A_SUBADDR_ADDR + 12'(4 * p), code);
    wr(PORT_A_SUBCTRL_ADDR + 12'(4 * p), d);
  endtask

  task automatic sub_rd(input int p, input logic [7:0] code, input logic [7:0] exp);
    wr(PORT_A_SUBADDR_ADDR + 12'(4 * p), code);
    rd(PORT_A_SUBCTRL_ADDR + 12'(4 * p), exp, "subregister");
  endtask

  // Hang guard, well above the fewer than 150 cycles the sequence needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      wrap_up();
    end
  end

  // ==========================================
  // Main sequence
  initial begin
    reset = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    ext_level = 24'h3CA596;
    alt_out = 24'h000000;
    alt_oe = 24'h000000;
    bad_count = 0;
    num_checks = 0;
    cycles = 0;
    repeat (4) @(posedge ref_clk);
    #1;
    chk("pin_oe in reset", 24'h000000, pin_oe);
    chk("led outputs in reset", 24'h000000, {led_sink_on, led_level_code});
    @(posedge ref_clk);
    reset <= 1'b0;
    rd(LED_SINK_ENABLE_ADDR, 8'h00, "led enable reset");
    rd(LED_LEVEL_UPPER_ADDR, 8'h00, "led upper reset");
    rd(LED_LEVEL_LOWER_ADDR, 8'h00, "led lower reset");
    for (int p = 0; p < 3; p++) begin
      rd(PORT_A_OUTPUT_ADDR + 12'(4 * p), 8'h00, "output value reset");
      sub_rd(p, SUB_ALT_SELECT_SECOND, 8'h00);
      chk("small select", (p == 0) ? 24'h000004 : 24'h000000, {16'h0000, small_rdata});
      sub_wr(p, SUB_ALT_SELECT_SECOND, 8'(8'h31 + p));
      sub_rd(p, SUB_ALT_SELECT_SECOND, 8'(8'h31 + p));
      wr(PORT_A_OUTPUT_ADDR + 12'(4 * p), 8'(8'hC3 >> p));
      rd(PORT_A_OUTPUT_ADDR + 12'(4 * p), 8'(8'hC3 >> p), "output value");
    end
    #1;
    chk("pin_oe with inputs", 24'h000000, pin_oe);
    // Pin sampling, including the synchroniser delay on a level change
    rd(PORT_A_SAMPLE_ADDR, 8'h96, "port a sample");
    rd(PORT_C_SAMPLE_ADDR, 8'h3C & C_BONDED, "port c sample");
    @(posedge ref_clk);
    ext_level <= 24'h3C5A96;
    rd(PORT_B_SAMPLE_ADDR, 8'hA5, "port b before sync");
    rd(PORT_B_SAMPLE_ADDR, 8'h5A, "port b sample");
    wr(PORT_A_SAMPLE_ADDR, 8'h00);
    rd(PORT_A_SAMPLE_ADDR, 8'h96, "sample after write");
    wr(12'h123, 8'h77);
    rd(12'h123, 8'h00, "unmapped read");
    @(posedge ref_clk);
    #1;
    chk("read data after slot", 24'h000000, {16'h0000, reg_rdata});
    // Output drive, open drain, alternate routing on port A
    wr(PORT_A_OUTPUT_ADDR, 8'hA5);
    sub_wr(0, SUB_DIRECTION, 8'h00);
    @(negedge ref_clk);
    chk("pin_oe output", 24'h0000FF, pin_oe);
    chk("pin_out output", 24'h0000A5, pin_out & 24'h0000FF);
    repeat (2) @(posedge ref_clk);
    rd(PORT_A_SAMPLE_ADDR, 8'hA5, "driven pins sampled");
    sub_wr(0, SUB_OPEN_DRAIN, 8'hF0);
    @(negedge ref_clk);
    chk("open drain oe", 24'h00005F, pin_oe);
    chk("open drain out", 24'h000005, pin_out & 24'h00005F);
    @(posedge ref_clk);
    alt_out <= 24'h00000A;
    alt_oe <= 24'h000006;
    sub_wr(0, SUB_ALT_SELECT_SECOND, 8'h33);
    @(negedge ref_clk);
    chk("set2 without enable", 24'h000000, alt_set2_active);
    chk("oe without enable", 24'h00005F, pin_oe);
    sub_wr(0, SUB_ALT_ENABLE, 8'h0F);
    @(negedge ref_clk);
    chk("set2 with enable", 24'h000003, alt_set2_active);
    chk("alt oe", 24'h000056, pin_oe);
    chk("alt out", 24'h000002, pin_out & 24'h000056);
    // LED sink on Port C, alternate enable set to show it has no say
    sub_wr(2, SUB_ALT_ENABLE, 8'hFF);
    hi = 8'hCC;
    lo = 8'hAA;
    wr(LED_SINK_ENABLE_ADDR, 8'h5A);
    wr(LED_LEVEL_UPPER_ADDR, hi);
    wr(LED_LEVEL_LOWER_ADDR, lo);
    @(negedge ref_clk);
    chk("led sink on", 24'h00005A, {16'h0000, led_sink_on});
    for (int n = 0; n < 8; n++) begin
      exp_code[2 * n +: 2] = {hi[n], lo[n]};
    end
    chk("led level code", {8'h00, exp_code}, {8'h00, led_level_code});
    rd(LED_SINK_ENABLE_ADDR, 8'h5A, "led enable");
    rd(LED_LEVEL_UPPER_ADDR, hi, "led upper");
    rd(LED_LEVEL_LOWER_ADDR, lo, "led lower");
    // Mid-run reset must undo every write made above
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    chk("pin_oe after reset", 24'h000000, pin_oe);
    chk("led outputs after reset", 24'h000000, {led_sink_on, led_level_code});
    @(posedge ref_clk);
    reset <= 1'b0;
    rd(LED_LEVEL_UPPER_ADDR, 8'h00, "led upper after reset");
    rd(PORT_C_OUTPUT_ADDR, 8'h00, "output value after reset");
    sub_rd(0, SUB_ALT_SELECT_SECOND, 8'h00);
    chk("small select after reset", 24'h000004, {16'h0000, small_rdata});
    wrap_up();
  end
endmodule
